// ==== core/port_enable_recovery_cmds.sv ====
// Command interpreter for port enable, ADC mode and reference, and
// power-out recovery settings, plus the ADC threshold check reply.
// Assumes framed command bytes with a last flag; the reply sink
// may stall through tx_ready.
//
// Functional notes
// R1 - Comma byte between every port group
// R2 - Code 11 carries 34 enable bytes
// R3 - Mode byte 31 level, 32 switch
// R4 - Reference 30 supply, 31 internal, 32 external
// R5 - Port byte 31 enables, 32 disables
// R6 - All ports enabled after reset
// R7 - All ADC inputs level after reset
// R8 - Enable reply code 12, 37 bytes
// R9 - Enable status 30 ok, 31, 39
// R10 - Code 13 answered like code 11
// R11 - Check replies report status 30
// R12 - Threshold check reply reports status 30
// R13 - Threshold default is 0000
// R14 - Code 14 carries twelve recovery bytes
// R15 - Recovery reply code 15, 15 bytes
// R16 - Code 16 answered like code 14
// R17 - Recovery enabled on every output
// R18 - Run mode answers not-in-setting status
// R19 - Refused update keeps stored settings
//
// Register access over Avalon-MM and the register addresses were decided locally.
`timescale 1ns/1ps
`include "pe_regs.svh"

module port_enable_recovery_cmds (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire pe_pkg::byte_s rx,
    output logic               rx_ready,
    output pe_pkg::byte_s      tx,
    input  wire logic          tx_ready,
    output pe_pkg::cfg_s       cfg
);
    pe_pkg::state_e   state, next_state;
    pe_pkg::reply_e   kind, next_kind;
    pe_pkg::cfg_s     sh, next_sh, next_cfg;
    pe_pkg::byte_s    next_tx;
    logic [15:0]      code, next_code;
    logic [5:0]       cnt, next_cnt;
    logic [5:0]       txi, next_txi;
    logic [7:0]       status, next_status;
    logic             err, next_err;
    logic             next_rx_ready;
    logic             setting, factory, take, load, finish, fin_err, bad_sep;
    logic [1:0]       pb;
    logic [5:0]       p;
    logic [4:0]       s_in, s_out, s_rec;
    logic [7:0]       rep_byte;
    logic [3:0][31:0] thr;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic pe_pkg::reply_e kind_of(input logic [15:0] c);
        case (c)
            `PE_CMD_SET_EN, `PE_CMD_CHK_EN:   kind_of = pe_pkg::RK_EN;
            `PE_CMD_SET_REC, `PE_CMD_CHK_REC: kind_of = pe_pkg::RK_REC;
            `PE_CMD_CHK_ADC:                  kind_of = pe_pkg::RK_ADC;
            default:                          kind_of = pe_pkg::RK_NONE;
        endcase
    endfunction : kind_of

    function automatic logic is_set(input logic [15:0] c);
        is_set = (c == `PE_CMD_SET_EN) || (c == `PE_CMD_SET_REC);
    endfunction : is_set

    function automatic logic [5:0] exp_len(input logic [15:0] c);
        exp_len = (c == `PE_CMD_SET_EN) ? `PE_LEN_EN : (c == `PE_CMD_SET_REC) ? `PE_LEN_REC : `PE_LEN_CHK;
    endfunction : exp_len

    function automatic logic [5:0] tx_len(input pe_pkg::reply_e k);
        tx_len = (k == pe_pkg::RK_EN) ? `PE_TX_EN : (k == pe_pkg::RK_REC) ? `PE_TX_REC : `PE_TX_ADC;
    endfunction : tx_len

    // {illegal, enable}: only the two enable codes are accepted
    function automatic logic [1:0] port_bit(input logic [7:0] b);
        port_bit = {b != `PE_CH1 && b != `PE_CH2, b == `PE_CH1}; // R3 R5
    endfunction : port_bit

    cmd_regs u_regs (
        .mclk            (mclk),
        .rstn            (rstn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .status          (status),
        .busy            (state != pe_pkg::ST_IDLE),
        .cfg             (cfg),
        .setting         (setting),
        .factory         (factory),
        .thr             (thr)
    );

    reply_gen u_reply (
        .kind   (kind),
        .status (status),
        .cfg    (cfg),
        .thr    (thr),
        .idx    (txi),
        .data   (rep_byte)
    );

    assign take = rx.valid && rx_ready;

    // ----------------------------------------------------------------
    // Parser and reply sequencer
    // ----------------------------------------------------------------
    always_comb begin
        next_state    = state;
        next_kind     = kind;
        next_code     = code;
        next_cnt      = cnt;
        next_err      = err;
        next_sh       = sh;
        next_cfg      = cfg;
        next_status   = status;
        next_txi      = txi;
        next_tx       = tx;
        next_rx_ready = rx_ready;
        finish        = 1'b0;
        load          = 1'b0;
        fin_err       = 1'b0;
        pb            = port_bit(rx.data);
        bad_sep       = rx.data != `PE_SEP;
        p             = cnt + 6'h01;
        s_in          = pe_pkg::slot(p - 6'h07);
        s_out         = pe_pkg::slot(p - 6'h16);
        s_rec         = pe_pkg::slot(p);
        if (tx_ready) begin
            next_tx.valid = 1'b0;
        end
        if (factory) begin
            next_cfg = pe_pkg::cfg_s'(`PE_CFG_RESET); // R6 R7 R17
        end
        case (state)
            pe_pkg::ST_IDLE: begin
                // A lone byte cannot hold a code and is dropped
                if (take && !rx.last) begin
                    next_code  = {rx.data, 8'h00};
                    next_state = pe_pkg::ST_CODE;
                end
            end
            pe_pkg::ST_CODE: begin
                if (take) begin
                    next_code = {code[15:8], rx.data};
                    next_kind = kind_of(next_code);
                    next_sh   = cfg;
                    next_cnt  = 6'h00;
                    next_err  = 1'b0;
                    if (next_kind == pe_pkg::RK_NONE) begin
                        next_state = rx.last ? pe_pkg::ST_IDLE : pe_pkg::ST_DROP;
                    end else if (rx.last) begin
                        finish  = 1'b1;
                        fin_err = 1'b1;
                    end else begin
                        next_state = pe_pkg::ST_DATA;
                    end
                end
            end
            pe_pkg::ST_DATA: begin
                if (take) begin
                    if (cnt < `PE_LEN_CAP) begin
                        next_cnt = p;
                    end
                    if (code == `PE_CMD_SET_EN) begin // R2
                        if (p <= 6'h04) begin
                            next_sh.adc_switch[2'(p - 6'h01)] = !pb[0]; // R3
                            next_err = err | pb[1];
                        end else if (p == 6'h05 || p == 6'h07 || p == 6'h16) begin
                            next_err = err | bad_sep; // R1
                        end else if (p == 6'h06) begin
                            next_sh.adc_ref = rx.data[1:0]; // R4
                            next_err = err | rx.data < `PE_CH0 | rx.data > `PE_CH2;
                        end else if (p <= 6'h15) begin
                            if (s_in[4]) begin
                                next_err = err | bad_sep; // R1
                            end else begin
                                next_sh.in_en[s_in[3:0]] = pb[0]; // R5
                                next_err = err | pb[1];
                            end
                        end else if (p <= `PE_LEN_EN) begin
                            if (s_out[4]) begin
                                next_err = err | bad_sep; // R1
                            end else begin
                                next_sh.out_en[s_out[3:0]] = pb[0]; // R5
                                next_err = err | pb[1];
                            end
                        end
                    end else if (code == `PE_CMD_SET_REC && p <= `PE_LEN_REC) begin
                        if (s_rec[4]) begin
                            next_err = err | bad_sep; // R1
                        end else begin
                            next_sh.out_rec[s_rec[3:0]] = pb[0]; // R14
                            next_err = err | pb[1];
                        end
                    end
                    if (rx.last) begin
                        finish  = 1'b1;
                        fin_err = next_err | (p != exp_len(code)); // R2 R14
                    end
                end
            end
            pe_pkg::ST_DROP: begin
                if (take && rx.last) begin
                    next_state = pe_pkg::ST_IDLE;
                end
            end
            pe_pkg::ST_SEND: begin
                if (!tx.valid || tx_ready) begin
                    load          = 1'b1;
                    next_tx.valid = 1'b1;
                    next_tx.data  = rep_byte;
                    next_tx.last  = txi == tx_len(kind) - 6'h01; // R8 R15
                    next_txi      = txi + 6'h01;
                    if (next_tx.last) begin
                        next_state    = pe_pkg::ST_IDLE;
                        next_rx_ready = 1'b1;
                    end
                end
            end
            default: begin
                next_state = pe_pkg::ST_IDLE;
            end
        endcase
        if (finish) begin
            next_state    = pe_pkg::ST_SEND;
            next_txi      = 6'h00;
            next_rx_ready = 1'b0;
            if (!is_set(next_code)) begin
                next_status = `PE_CH0; // R10 R11 R12 R16
            end else if (!setting) begin
                next_status = `PE_CH1; // R18 R19
            end else if (fin_err) begin
                next_status = `PE_CH9; // R9 R19
            end else begin
                next_status = `PE_CH0; // R9
                next_cfg    = next_sh;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            state    <= pe_pkg::ST_IDLE;
            kind     <= pe_pkg::RK_NONE;
            code     <= 16'h0000;
            cnt      <= 6'h00;
            err      <= 1'b0;
            sh       <= pe_pkg::cfg_s'(`PE_CFG_RESET);
            cfg      <= pe_pkg::cfg_s'(`PE_CFG_RESET); // R6 R7 R17
            status   <= `PE_CH0;
            txi      <= 6'h00;
            tx       <= '0;
            rx_ready <= 1'b1;
        end else begin
            state    <= next_state;
            kind     <= next_kind;
            code     <= next_code;
            cnt      <= next_cnt;
            err      <= next_err;
            sh       <= next_sh;
            cfg      <= next_cfg;
            status   <= next_status;
            txi      <= next_txi;
            tx       <= next_tx;
            rx_ready <= next_rx_ready;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_sep_reply: assert property ( // R1
        @(posedge mclk) disable iff (!rstn)
        load && kind == pe_pkg::RK_EN && txi == 6'h07 |=> tx.data == `PE_SEP)
        else $error("Comma missing in enable reply");

    chk_en_length: assert property ( // R8 R10
        @(posedge mclk) disable iff (!rstn)
        tx.valid && tx.last && kind == pe_pkg::RK_EN |-> txi == `PE_TX_EN)
        else $error("Enable reply length wrong");

    chk_en_code: assert property ( // R8
        @(posedge mclk) disable iff (!rstn)
        load && kind == pe_pkg::RK_EN && txi == 6'h01 |=> tx.data == `PE_CH2)
        else $error("Enable reply code wrong");

    chk_rec_length: assert property ( // R15 R16
        @(posedge mclk) disable iff (!rstn)
        tx.valid && tx.last && kind == pe_pkg::RK_REC |-> txi == `PE_TX_REC)
        else $error("Recovery reply length wrong");

    chk_mode_store: assert property ( // R3
        @(posedge mclk) disable iff (!rstn)
        state == pe_pkg::ST_DATA && take && code == `PE_CMD_SET_EN && cnt == 6'h00
        && rx.data == `PE_CH2 |=> sh.adc_switch[0])
        else $error("Switch mode byte not stored");

    chk_ref_store: assert property ( // R4
        @(posedge mclk) disable iff (!rstn)
        state == pe_pkg::ST_DATA && take && code == `PE_CMD_SET_EN && cnt == 6'h05
        && rx.data == `PE_CH1 |=> sh.adc_ref == 2'h1)
        else $error("Internal reference not stored");

    chk_port_store: assert property ( // R5
        @(posedge mclk) disable iff (!rstn)
        state == pe_pkg::ST_DATA && take && code == `PE_CMD_SET_EN && cnt == 6'h07
        && rx.data == `PE_CH2 |=> !sh.in_en[0])
        else $error("Input disable not stored");

    chk_rec_store: assert property ( // R14
        @(posedge mclk) disable iff (!rstn)
        state == pe_pkg::ST_DATA && take && code == `PE_CMD_SET_REC && cnt == 6'h00
        && rx.data == `PE_CH2 |=> !sh.out_rec[0])
        else $error("Recovery disable not stored");

    chk_factory_cfg: assert property ( // R6 R7 R17
        @(posedge mclk) disable iff (!rstn)
        factory && !finish |=> cfg == pe_pkg::cfg_s'(`PE_CFG_RESET))
        else $error("Factory defaults not applied");

    chk_run_status: assert property ( // R18 R19
        @(posedge mclk) disable iff (!rstn)
        finish && is_set(next_code) && !setting && !factory |=> status == `PE_CH1 && cfg == $past(cfg))
        else $error("Run mode update not refused");

    chk_bad_status: assert property ( // R9 R19
        @(posedge mclk) disable iff (!rstn)
        finish && is_set(next_code) && setting && fin_err && !factory
        |=> status == `PE_CH9 && cfg == $past(cfg))
        else $error("Bad payload not refused");

    chk_commit: assert property ( // R9
        @(posedge mclk) disable iff (!rstn)
        finish && is_set(next_code) && setting && !fin_err |=> status == `PE_CH0 && cfg == sh)
        else $error("Good payload not committed");

    chk_check_ok: assert property ( // R11 R12
        @(posedge mclk) disable iff (!rstn)
        finish && !is_set(next_code) |=> (status == `PE_CH0) [*2])
        else $error("Check reply status not normal");
endmodule : port_enable_recovery_cmds

// ==== core/pe_regs.svh ====
// Register map, field positions, reset values and byte codes of the
// port enable and recovery command interpreter.
// Assumes word-addressed Avalon-MM access with 32-bit data.
`ifndef PE_REGS_SVH
`define PE_REGS_SVH

`define PE_REG_CTRL   4'h0
`define PE_REG_STATUS 4'h1
`define PE_REG_PORTS  4'h2
`define PE_REG_RECOV  4'h3
`define PE_REG_THR0   4'h4
`define PE_REG_THR1   4'h5
`define PE_REG_THR2   4'h6
`define PE_REG_THR3   4'h7
`define PE_CTRL_SET   0
`define PE_CTRL_FACT  1

`define PE_THR_RESET  32'h30303030
`define PE_CFG_RESET  38'h0ffffffff

`define PE_SEP        8'h2c
`define PE_CH0        8'h30
`define PE_CH1        8'h31
`define PE_CH2        8'h32
`define PE_CH9        8'h39

`define PE_CMD_CHK_ADC 16'h3130
`define PE_CMD_SET_EN  16'h3131
`define PE_CMD_CHK_EN  16'h3133
`define PE_CMD_SET_REC 16'h3134
`define PE_CMD_CHK_REC 16'h3136

`define PE_LEN_EN     6'h22
`define PE_LEN_REC    6'h0c
`define PE_LEN_CHK    6'h01
`define PE_LEN_CAP    6'h28
`define PE_TX_EN      6'h25
`define PE_TX_REC     6'h0f
`define PE_TX_ADC     6'h13

`endif

// ==== core/pe_pkg.sv ====
// Types and shared decode helpers of the command interpreter.
// Assumes pe_regs.svh on the include path.
`include "pe_regs.svh"

package pe_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CODE = 3'b001,
        ST_DATA = 3'b010,
        ST_DROP = 3'b011,
        ST_SEND = 3'b100
    } state_e;

    typedef enum logic [1:0] {
        RK_NONE = 2'b00,
        RK_EN   = 2'b01,
        RK_REC  = 2'b10,
        RK_ADC  = 2'b11
    } reply_e;

    typedef struct packed {
        logic [3:0]  adc_switch;
        logic [1:0]  adc_ref;
        logic [11:0] in_en;
        logic [9:0]  out_en;
        logic [9:0]  out_rec;
    } cfg_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
    } byte_s;

    // Position in a run of four ports then a comma: {is_comma, port}
    function automatic logic [4:0] slot(input logic [5:0] pos);
        logic [5:0] z;
        z    = pos - 6'h01;
        slot = {pos % 6'h05 == 6'h00, 4'(z - z / 6'h05)};
    endfunction : slot

    function automatic logic [7:0] en_byte(input logic on);
        en_byte = on ? `PE_CH1 : `PE_CH2;
    endfunction : en_byte
endpackage : pe_pkg

// ==== core/reply_gen.sv ====
// Byte generator for the three reply formats, addressed by index.
// Assumes the caller holds the stored settings stable during a reply.
`timescale 1ns/1ps
`include "pe_regs.svh"

module reply_gen (
    input  wire pe_pkg::reply_e kind,
    input  wire logic [7:0]     status,
    input  wire pe_pkg::cfg_s   cfg,
    input  wire logic [127:0]   thr,
    input  wire logic [5:0]     idx,
    output logic [7:0]          data
);
    logic [5:0]   e;
    logic [4:0]   s;
    logic [127:0] tw;

    always_comb begin
        e    = idx - 6'h02;
        s    = 5'h00;
        tw   = thr << {e - 6'h01, 3'b000};
        data = `PE_SEP;
        if (idx == 6'h00) begin
            data = (kind == pe_pkg::RK_ADC) ? `PE_CH0 : `PE_CH1;
        end else if (idx == 6'h01) begin
            data = (kind == pe_pkg::RK_ADC) ? `PE_CH9 : (kind == pe_pkg::RK_REC) ? 8'h35 : `PE_CH2;
        end else if (e == 6'h00) begin
            data = status;
        end else if (kind == pe_pkg::RK_ADC) begin
            data = tw[127:120];
        end else if (kind == pe_pkg::RK_REC) begin
            s = pe_pkg::slot(e);
            if (!s[4]) begin
                data = pe_pkg::en_byte(cfg.out_rec[s[3:0]]);
            end
        end else if (e <= 6'h04) begin
            data = cfg.adc_switch[2'(e - 6'h01)] ? `PE_CH2 : `PE_CH1;
        end else if (e == 6'h06) begin
            data = `PE_CH0 + {6'h00, cfg.adc_ref};
        end else if (e >= 6'h08 && e <= 6'h15) begin
            s = pe_pkg::slot(e - 6'h07);
            if (!s[4]) begin
                data = pe_pkg::en_byte(cfg.in_en[s[3:0]]);
            end
        end else if (e >= 6'h17) begin
            s = pe_pkg::slot(e - 6'h16);
            if (!s[4]) begin
                data = pe_pkg::en_byte(cfg.out_en[s[3:0]]);
            end
        end
    end
endmodule : reply_gen

// ==== core/cmd_regs.sv ====
// Avalon-MM register slave: setting mode, factory reset, thresholds.
// Assumes a master that holds each request until waitrequest is low.
`timescale 1ns/1ps
`include "pe_regs.svh"

module cmd_regs (
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic [3:0]    avs_address,
    input  wire logic          avs_read,
    input  wire logic          avs_write,
    input  wire logic [31:0]   avs_writedata,
    output logic [31:0]        avs_readdata,
    output logic               avs_waitrequest,
    input  wire logic [7:0]    status,
    input  wire logic          busy,
    input  wire pe_pkg::cfg_s  cfg,
    output logic               setting,
    output logic               factory,
    output logic [3:0][31:0]   thr
);
    logic [3:0][31:0] next_thr;
    logic [31:0]      next_rdata;
    logic [31:0]      rd;
    logic             next_wait;
    logic             next_setting;
    logic             next_factory;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    always_comb begin
        rd = 32'h0;
        case (avs_address)
            `PE_REG_CTRL:   rd[`PE_CTRL_SET] = setting;
            `PE_REG_STATUS: rd = {23'h0, busy, status};
            `PE_REG_PORTS:  rd = {4'h0, cfg.adc_switch, cfg.adc_ref, cfg.in_en, cfg.out_en};
            `PE_REG_RECOV:  rd = {22'h0, cfg.out_rec};
            `PE_REG_THR0, `PE_REG_THR1, `PE_REG_THR2, `PE_REG_THR3: rd = thr[~avs_address[1:0]];
            default:        rd = 32'h0;
        endcase
        next_wait    = 1'b1;
        next_rdata   = avs_readdata;
        next_setting = setting;
        next_factory = 1'b0;
        next_thr     = thr;
        // One wait cycle per access, so read data comes from a register
        if ((avs_read || avs_write) && avs_waitrequest) begin
            next_wait = 1'b0;
            if (avs_read) begin
                next_rdata = rd;
            end
        end
        if (avs_write && !avs_waitrequest) begin
            if (avs_address == `PE_REG_CTRL) begin
                next_setting = avs_writedata[`PE_CTRL_SET];
                next_factory = avs_writedata[`PE_CTRL_FACT];
            end else if (avs_address[3:2] == 2'b01) begin
                next_thr[~avs_address[1:0]] = avs_writedata;
            end
        end
        if (factory) begin
            next_thr = {4{`PE_THR_RESET}}; // R13
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0;
            setting         <= 1'b0;
            factory         <= 1'b0;
            thr             <= {4{`PE_THR_RESET}};
        end else begin
            avs_waitrequest <= next_wait;
            avs_readdata    <= next_rdata;
            setting         <= next_setting;
            factory         <= next_factory;
            thr             <= next_thr;
        end
    end

    chk_thr_factory: assert property ( // R13
        @(posedge mclk) disable iff (!rstn)
        factory |=> thr == {4{`PE_THR_RESET}})
        else $error("Thresholds not back to zero after factory reset");
endmodule : cmd_regs

// ==== sim/host_model.sv ====
// Remote host model: sends command frames and collects reply bytes.
// Assumes the interpreter's valid/ready byte stream on both sides.
`timescale 1ns/1ps
module host_model (
    input  wire logic          mclk,
    input  wire logic          slow,
    output pe_pkg::byte_s      rx,
    input  wire logic          rx_ready,
    input  wire pe_pkg::byte_s tx,
    output logic               tx_ready
);
    logic [7:0] got [$];
    initial {rx, tx_ready} = 11'h001;
    // Slow mode stalls every other cycle to exercise the held reply byte
    always @(posedge mclk) begin
        if (tx.valid === 1'b1 && tx_ready)
            got.push_back(tx.data);
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
    task automatic send(input logic [7:0] f [$]);
        got = {};
        foreach (f[i]) begin
            rx <= '{1'b1, f[i], i == f.size() - 1};
            @(posedge mclk);
            while (rx_ready !== 1'b1)
                @(posedge mclk);
        end
        rx <= '0;
    endtask : send
endmodule : host_model

// ==== sim/test_port_enable_recovery_cmds.sv ====
// Bench for the command interpreter: a row table, then reset cases.
// Assumes the host model beside it and a 40 MHz clock.
`timescale 1ns/1ps
`include "pe_regs.svh"
module test_port_enable_recovery_cmds;
    typedef struct packed {logic [15:0] code; logic set; logic bad; pe_pkg::cfg_s c;} row_s;
    logic          mclk = 1'b0, rstn, avs_read, avs_write, slow;
    logic          avs_waitrequest, rx_ready, tx_ready, en, is_set;
    logic [3:0]    avs_address;
    logic [31:0]   avs_writedata, rd, avs_readdata;
    logic [7:0]    st, cmd [$], exp [$];
    pe_pkg::byte_s rx, tx;
    pe_pkg::cfg_s  cfg, want;
    row_s          r;
    int            bad_count = 0, checks_done = 0;
    localparam pe_pkg::cfg_s DEF = {4'h0, 2'h0, 12'hfff, 10'h3ff, 10'h3ff};
    localparam pe_pkg::cfg_s CA = {4'h5, 2'h1, 12'ha5c, 10'h2b3, 10'h2a8};
    localparam row_s ROWS [9] = '{'{`PE_CMD_CHK_EN, 1'b0, 1'b0, DEF}, '{`PE_CMD_SET_EN, 1'b0, 1'b0, CA},
        '{`PE_CMD_SET_EN, 1'b1, 1'b0, CA}, '{`PE_CMD_SET_EN, 1'b1, 1'b0, {4'ha, 2'h2, 12'h5a3, 10'h14c, 10'h0}},
        '{`PE_CMD_CHK_REC, 1'b0, 1'b0, DEF}, '{`PE_CMD_SET_REC, 1'b1, 1'b0, CA},
        '{`PE_CMD_SET_EN, 1'b1, 1'b1, DEF}, '{`PE_CMD_SET_REC, 1'b0, 1'b0, DEF}, '{`PE_CMD_CHK_ADC, 1'b0, 1'b0, DEF}};
    port_enable_recovery_cmds port_enable_recovery_cmds_i (.mclk(mclk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx(rx), .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .cfg(cfg));
    host_model host_model_i (.mclk(mclk), .slow(slow), .rx(rx), .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] want_v);
        checks_done++;
        if (seen !== want_v) begin
            bad_count++;
            $display("mismatch t=%0t seen %h want %h", $time, seen, want_v);
        end
    endtask : check
    task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0)
            @(posedge mclk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask : bus
    task automatic add(inout logic [7:0] q [$], input logic [11:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            if (i % 4 == 0 && i > 0)
                q.push_back(8'h2c);
            q.push_back(v[i] ? 8'h31 : 8'h32);
        end
    endtask : add
    // Mode bytes invert: a switch-mode bit gives 0x32
    task automatic lay(input logic e, input pe_pkg::cfg_s c, inout logic [7:0] q [$]);
        if (e) begin
            add(q, {8'h0, ~c.adc_switch}, 4);
            q.push_back(8'h2c);
            q.push_back({6'h0c, c.adc_ref});
            q.push_back(8'h2c);
            add(q, c.in_en, 12);
            q.push_back(8'h2c);
            add(q, {2'h0, c.out_en}, 10);
        end else
            add(q, {2'h0, c.out_rec}, 10);
    endtask : lay
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (checks_done > 0 && bad_count == 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial forever #12.5 mclk = ~mclk;
    initial begin
        #500000;
        bad_count++;
        close_out();
    end
    initial begin
        {rstn, avs_read, avs_write, slow, avs_address, avs_writedata} <= '0;
        want = DEF;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        check(cfg, DEF);
        for (int i = 0; i < 9; i++) begin
            r = ROWS[i];
            bus(`PE_REG_CTRL, 1'b1, {31'h0, r.set}, rd);
            slow <= i[0];
            en = r.code == `PE_CMD_SET_EN || r.code == `PE_CMD_CHK_EN;
            is_set = r.code == `PE_CMD_SET_EN || r.code == `PE_CMD_SET_REC;
            st = !is_set ? 8'h30 : !r.set ? 8'h31 : r.bad ? 8'h39 : 8'h30;
            cmd = {r.code[15:8], r.code[7:0]};
            if (is_set)
                lay(en, r.c, cmd);
            else
                cmd.push_back(8'h30);
            if (r.bad)
                cmd[2] = 8'h33;
            if (st == 8'h30 && is_set && en)
                want[37:10] = r.c[37:10];
            if (st == 8'h30 && is_set && !en)
                want.out_rec = r.c.out_rec;
            exp = r.code == `PE_CMD_CHK_ADC ? {8'h30, 8'h39, st} : {8'h31, en ? 8'h32 : 8'h35, st};
            if (r.code == `PE_CMD_CHK_ADC)
                repeat (16) exp.push_back(8'h30);
            else
                lay(en, want, exp);
            host_model_i.send(cmd);
            for (int k = 0; k < 400 && host_model_i.got.size() < exp.size(); k++)
                @(posedge mclk);
            check(host_model_i.got.size(), exp.size());
            foreach (exp[j])
                check(host_model_i.got[j], exp[j]);
            check(cfg, want);
        end
        bus(`PE_REG_THR0, 1'b1, 32'h31303233, rd);
        bus(`PE_REG_CTRL, 1'b1, 32'h2, rd);
        bus(`PE_REG_THR0, 1'b0, 32'h0, rd);
        check(rd, 32'h30303030);
        check(cfg, DEF);
        bus(4'h8, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        close_out();
    end
endmodule : test_port_enable_recovery_cmds
